// [include/fifo_consts.svh]
// Register offsets, field positions and sizes of the shared byte buffer
`ifndef FIFO_CONSTS_SVH
`define FIFO_CONSTS_SVH
`define REG_DATA 8'h00
`define REG_CONTROL 8'h01
`define REG_THRESH_HI 8'h02
`define REG_THRESH_LO 8'h03
`define REG_FILL 8'h04
`define REG_IRQ_STATUS 8'h05
`define REG_IRQ_ENABLE 8'h06
`define CTRL_CLEAR_BIT 0
`define CTRL_CAP_BIT 1
`define CTRL_FILL_HI_BIT 2
`define CTRL_NEAR_EMPTY_BIT 3
`define CTRL_NEAR_FULL_BIT 4
`define CTRL_FILL_TOP_BIT 5
`define THRESH_HI_BIT 2
`define IRQ_ERR_BIT 0
`define IRQ_NEAR_EMPTY_BIT 1
`define IRQ_NEAR_FULL_BIT 2
`define IRQ_WIDTH 3
`define DEPTH_FULL 512
`define DEPTH_SMALL 255
`define THRESH_RESET 10'h008
`endif

// [include/fifo_pkg.sv]
// Types for the shared byte buffer
`default_nettype none
package fifo_pkg;
   typedef logic [9:0] level_t;
   typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// [design/byte_store.sv]
// Byte storage array with pointers, fill count and flush
`default_nettype none
`include "fifo_consts.svh"
module byte_store #(
   parameter int DEPTH = `DEPTH_FULL
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Control
   input wire logic clear,
   input wire logic small_cap,
   // Write side
   input wire logic wr_en,
   input wire fifo_pkg::byte_t wr_data,
   // Read side
   input wire logic rd_en,
   output fifo_pkg::byte_t rd_data,
   // Status
   output fifo_pkg::level_t count,
   output logic full,
   output logic empty
);
   fifo_pkg::byte_t mem [DEPTH];
   logic [8:0] wptr_r;
   logic [8:0] rptr_r;
   fifo_pkg::level_t count_r;
   fifo_pkg::level_t cap;
   logic do_wr;
   logic do_rd;

   assign cap = small_cap ? 10'(`DEPTH_SMALL) : 10'(DEPTH);
   assign full = (count_r >= cap);
   assign empty = (count_r == 10'h000);
   // Full write dropped, contents untouched
   assign do_wr = wr_en && !full;
   assign do_rd = rd_en && !empty;
   assign count = count_r;
   assign rd_data = mem[rptr_r];

   always_ff @(posedge pclk) begin
      if (ce && do_wr) begin
         mem[wptr_r] <= wr_data;
      end
   end

   // Pointer wrap at the selected capacity keeps 255-byte mode contiguous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_r <= 9'h000;
         rptr_r <= 9'h000;
         count_r <= 10'h000;
      end else if (ce) begin
         if (clear) begin
            wptr_r <= 9'h000;
            rptr_r <= 9'h000;
            count_r <= 10'h000;
         end else begin
            if (do_wr) begin
               wptr_r <= (10'(wptr_r) + 10'h001 >= cap) ? 9'h000 : wptr_r + 9'h001;
            end
            if (do_rd) begin
               rptr_r <= (10'(rptr_r) + 10'h001 >= cap) ? 9'h000 : rptr_r + 9'h001;
            end
            count_r <= count_r + 10'(do_wr) - 10'(do_rd);
         end
      end
   end
endmodule // byte_store
`default_nettype wire

// [design/shared_fifo.sv]
// Shared byte buffer with threshold flags, APB registers and interrupt
// Notes on behaviour
// - One byte-wide 512-entry buffer carries data both ways between host and command engine.
// - Capacity can be cut to 255 bytes so that count and threshold fit in one byte.
// - In 512-byte mode count and threshold each take two register bytes.
// - The command engine may read or write the buffer while a command runs.
// - Writing one to the clear bit resets both pointers and zeroes the fill count.
// - After a clear the buffer takes a full load again, 512 or 255 bytes.
// - Each write adds one and each read subtracts one from the fill count, readable any time.
// - In 512-byte mode the count's top bit sits in the buffer control register.
// - One threshold, bit 2 of register 02h plus register 03h, sets both alerts.
// - Near-full is one when capacity minus fill count is at most the threshold.
// - Near-empty is one when the fill count is at most the threshold.
// - A write into a full buffer sets the overflow flag, seen as the error interrupt flag.
// - With its enable set, the interrupt pin rises when near-empty turns to one.
// - With its enable set, the interrupt pin rises when near-full turns to one.
//
// The APB interface to the registers was decided locally.
`default_nettype none
`include "fifo_consts.svh"
module shared_fifo #(
   parameter int DEPTH = `DEPTH_FULL
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Command engine port
   input wire logic eng_wr,
   input wire fifo_pkg::byte_t eng_wdata,
   input wire logic eng_rd,
   output fifo_pkg::byte_t eng_rdata,
   // Status and interrupt
   output logic irq,
   output logic near_full_flag,
   output logic near_empty_flag
);
   logic capacity_select_r;
   fifo_pkg::level_t threshold_level_r;
   logic [`IRQ_WIDTH-1:0] interrupt_status_0_r;
   logic [`IRQ_WIDTH-1:0] interrupt_enable_0_r;
   logic near_full_d_r;
   logic near_empty_d_r;
   logic [31:0] rdata_nxt;
   logic addr_ok;
   logic setup;
   logic acc_wr;
   logic acc_rd;
   logic host_wr;
   logic host_rd;
   logic clear;
   logic st_full;
   logic st_empty;
   fifo_pkg::level_t fill_count_bits;
   fifo_pkg::level_t cap;
   fifo_pkg::byte_t rd_byte;
   logic near_full_c;
   logic near_empty_c;
   logic overflow_ev;
   logic [`IRQ_WIDTH-1:0] ev;

   // One-cycle access: pready rises in the cycle after setup
   assign setup = psel && !penable;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `REG_IRQ_ENABLE * 8'h04);
   assign acc_wr = psel && penable && pready && pwrite && addr_ok;
   assign acc_rd = psel && penable && pready && !pwrite && addr_ok;
   // Host and engine share one buffer; host is trusted to stay out of a running command
   // so in a simultaneous write the engine's byte goes in and the host's is dropped
   assign host_wr = acc_wr && (paddr == `REG_DATA * 8'h04) && !eng_wr;
   assign host_rd = acc_rd && (paddr == `REG_DATA * 8'h04) && !eng_rd;
   assign clear = acc_wr && (paddr == `REG_CONTROL * 8'h04) && pwdata[`CTRL_CLEAR_BIT];

   byte_store #(
      .DEPTH(DEPTH)
   ) u_store (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(clear),
      .small_cap(capacity_select_r),
      .wr_en(eng_wr || host_wr),
      .wr_data(eng_wr ? eng_wdata : fifo_pkg::byte_t'(pwdata[7:0])),
      .rd_en(eng_rd || host_rd),
      .rd_data(rd_byte),
      .count(fill_count_bits),
      .full(st_full),
      .empty(st_empty)
   );

   assign cap = capacity_select_r ? 10'(`DEPTH_SMALL) : 10'(DEPTH);
   assign near_full_c = ((cap - fill_count_bits) <= threshold_level_r);
   assign near_empty_c = (fill_count_bits <= threshold_level_r);
   assign overflow_ev = st_full && ((eng_wr || host_wr) && !clear);

   // Events: overflow, rising near-empty, rising near-full
   assign ev[`IRQ_ERR_BIT] = overflow_ev;
   assign ev[`IRQ_NEAR_EMPTY_BIT] = near_empty_c && !near_empty_d_r;
   assign ev[`IRQ_NEAR_FULL_BIT] = near_full_c && !near_full_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup && !addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capacity_select_r <= 1'b0;
         threshold_level_r <= `THRESH_RESET;
         interrupt_enable_0_r <= '0;
      end else if (ce && acc_wr) begin
         case (paddr)
            `REG_CONTROL * 8'h04: begin
               capacity_select_r <= pwdata[`CTRL_CAP_BIT];
            end
            `REG_THRESH_HI * 8'h04: begin
               // Upper threshold bit still counts in 255-byte mode, where setting it holds both alerts at one
               threshold_level_r[9:8] <= {1'b0, pwdata[`THRESH_HI_BIT]};
            end
            `REG_THRESH_LO * 8'h04: begin
               threshold_level_r[7:0] <= pwdata[7:0];
            end
            `REG_IRQ_ENABLE * 8'h04: begin
               interrupt_enable_0_r <= pwdata[`IRQ_WIDTH-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_status_0_r <= '0;
         near_full_d_r <= 1'b0;
         near_empty_d_r <= 1'b1;
      end else if (ce) begin
         near_full_d_r <= near_full_c;
         near_empty_d_r <= near_empty_c;
         if (acc_wr && paddr == `REG_IRQ_STATUS * 8'h04) begin
            interrupt_status_0_r <= (interrupt_status_0_r & ~pwdata[`IRQ_WIDTH-1:0]) | ev;
         end else begin
            interrupt_status_0_r <= interrupt_status_0_r | ev;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
         near_full_flag <= 1'b0;
         near_empty_flag <= 1'b1;
         eng_rdata <= 8'h00;
      end else if (ce) begin
         irq <= |(interrupt_status_0_r & interrupt_enable_0_r);
         near_full_flag <= near_full_c;
         near_empty_flag <= near_empty_c;
         eng_rdata <= rd_byte;
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         `REG_DATA * 8'h04: begin
            rdata_nxt[7:0] = rd_byte;
         end
         `REG_CONTROL * 8'h04: begin
            rdata_nxt[`CTRL_CAP_BIT] = capacity_select_r;
            rdata_nxt[`CTRL_FILL_HI_BIT] = fill_count_bits[8];
            // A full 512-byte load needs count bit 9 as well, or it would read as empty
            rdata_nxt[`CTRL_FILL_TOP_BIT] = fill_count_bits[9];
            rdata_nxt[`CTRL_NEAR_EMPTY_BIT] = near_empty_c;
            rdata_nxt[`CTRL_NEAR_FULL_BIT] = near_full_c;
         end
         `REG_THRESH_HI * 8'h04: begin
            rdata_nxt[`THRESH_HI_BIT] = threshold_level_r[8];
         end
         `REG_THRESH_LO * 8'h04: begin
            rdata_nxt[7:0] = threshold_level_r[7:0];
         end
         `REG_FILL * 8'h04: begin
            rdata_nxt[7:0] = fill_count_bits[7:0];
         end
         `REG_IRQ_STATUS * 8'h04: begin
            rdata_nxt[`IRQ_WIDTH-1:0] = interrupt_status_0_r;
         end
         `REG_IRQ_ENABLE * 8'h04: begin
            rdata_nxt[`IRQ_WIDTH-1:0] = interrupt_enable_0_r;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // Read data registered at setup so the access cycle presents it from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && setup && !pwrite) begin
         prdata <= rdata_nxt;
      end
   end
endmodule // shared_fifo
`default_nettype wire

// [sim/engine_model.sv]
// Command engine stand-in that pushes and pops bytes
`default_nettype none
module engine_model (
   // Clock
   input wire logic pclk,
   // Engine port
   output logic eng_wr,
   output fifo_pkg::byte_t eng_wdata,
   output logic eng_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      eng_wr = 1'b0;
      eng_rd = 1'b0;
      eng_wdata = 8'h00;
   end
   // One byte per cycle, values count up from zero
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         eng_wr <= 1'b1;
         eng_wdata <= 8'(i);
      end
      @(posedge pclk);
      eng_wr <= 1'b0;
      eng_wdata <= 8'hA5;
   endtask
   task automatic pop(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         eng_rd <= 1'b1;
      end
      @(posedge pclk);
      eng_rd <= 1'b0;
   endtask
endmodule // engine_model
`default_nettype wire

// [sim/shared_fifo_checker.sv]
// Port assertions for the shared byte buffer
`default_nettype none
module shared_fifo_checker #(
   parameter int DEPTH = 512
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic eng_wr,
   input wire logic eng_rd,
   input wire logic irq,
   input wire logic near_full_flag,
   input wire logic near_empty_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup, wr_ok;
   logic [1:0] act_r;
   assign setup = psel && !penable && ce;
   assign wr_ok = psel && penable && pready && pwrite;
   // Flags may only move shortly after traffic that can change count or threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) act_r <= 2'h0;
      else if (eng_wr || eng_rd || psel) act_r <= 2'h3;
      else if (act_r != 2'h0) act_r <= act_r - 2'h1;
   end
   ready_next_a: assert property (setup |=> pready && psel && penable)
      else $error("no pready after setup");
   ready_once_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   err_map_a: assert property (setup && (paddr > 8'h18 || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access not refused");
   err_none_a: assert property (setup && paddr <= 8'h18 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returns data");
   clear_empty_a: assert property (wr_ok && paddr == 8'h04 && pwdata[0] |-> ##[1:2] near_empty_flag)
      else $error("clear left buffer not empty");
   irq_mask_a: assert property (wr_ok && paddr == 8'h18 && pwdata[2:0] == 3'h0 |-> ##[1:2] !irq)
      else $error("irq with all enables off");
   flag_cause_a: assert property ($changed(near_full_flag) || $changed(near_empty_flag) |-> act_r != 2'h0)
      else $error("flag moved without traffic");
   cover property (pslverr);
   cover property (near_full_flag);
   cover property ($rose(irq));
endmodule // shared_fifo_checker
bind shared_fifo shared_fifo_checker #(.DEPTH(DEPTH)) i_shared_fifo_checker (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng_wr(eng_wr),
   .eng_rd(eng_rd), .irq(irq), .near_full_flag(near_full_flag),
   .near_empty_flag(near_empty_flag));
`default_nettype wire

// [sim/shared_fifo_with_watermark_bench.sv]
// Bench for the shared byte buffer
`default_nettype none
module shared_fifo_with_watermark_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, nf, ne, eng_wr, eng_rd, err;
   fifo_pkg::byte_t eng_wdata, eng_rdata;
   int err_total = 0, n_checks = 0;
   shared_fifo #(.DEPTH(512)) i_shared_fifo (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng_wr(eng_wr),
      .eng_wdata(eng_wdata), .eng_rd(eng_rd), .eng_rdata(eng_rdata), .irq(irq),
      .near_full_flag(nf), .near_empty_flag(ne));
   engine_model i_engine_model (.pclk(pclk), .eng_wr(eng_wr), .eng_wdata(eng_wdata),
      .eng_rd(eng_rd));
   initial forever #5 pclk = ~pclk;
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Outputs read right after the edge still hold the values sampled at it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      chk(32'({irq, nf, ne}), 32'h1);
      presetn <= 1'b1;
      rchk(8'h0C, 32'h08);
      rchk(8'h04, 32'h08);
      i_engine_model.push(8);
      settle();
      chk(32'(ne), 32'h1);
      i_engine_model.push(1);
      settle();
      chk(32'(ne), 32'h0);
      rchk(8'h10, 32'h09);
      @(posedge pclk);
      ce <= 1'b0;
      i_engine_model.push(2);
      @(posedge pclk);
      ce <= 1'b1;
      rchk(8'h10, 32'h09);
      apb(1'b1, 8'h18, 32'h2);
      rchk(8'h00, 32'h00);
      settle();
      chk(32'(irq), 32'h1);
      rchk(8'h14, 32'h2);
      chk(32'(eng_rdata), 32'h01);
      i_engine_model.pop(1);
      settle();
      chk(32'(eng_rdata), 32'h02);
      rchk(8'h10, 32'h07);
      apb(1'b1, 8'h14, 32'h2);
      settle();
      chk(32'(irq), 32'h0);
      apb(1'b1, 8'h18, 32'h4);
      i_engine_model.push(496);
      settle();
      chk(32'({nf, irq}), 32'h0);
      i_engine_model.push(1);
      settle();
      chk(32'({nf, irq}), 32'h3);
      i_engine_model.push(8);
      rchk(8'h10, 32'h00);
      rchk(8'h04, 32'h30);
      apb(1'b1, 8'h18, 32'h1);
      settle();
      chk(32'(irq), 32'h0);
      apb(1'b1, 8'h00, 32'hAB);
      settle();
      chk(32'(irq), 32'h1);
      rchk(8'h14, 32'h5);
      rchk(8'h04, 32'h30);
      apb(1'b1, 8'h14, 32'h7);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h04, 32'h1);
      rchk(8'h04, 32'h08);
      rchk(8'h10, 32'h00);
      apb(1'b1, 8'h04, 32'h3);
      i_engine_model.push(255);
      rchk(8'h10, 32'hFF);
      rchk(8'h04, 32'h12);
      apb(1'b1, 8'h14, 32'h7);
      i_engine_model.push(1);
      rchk(8'h14, 32'h1);
      rchk(8'h10, 32'hFF);
      apb(1'b1, 8'h08, 32'h4);
      rchk(8'h08, 32'h4);
      settle();
      chk(32'(ne), 32'h1);
      rchk(8'h40, 32'h0);
      chk(32'(err), 32'h1);
      summarize();
   end
endmodule // shared_fifo_with_watermark_bench
`default_nettype wire
